// *** rtl/shared_pin_gpio_map.vh ***
// Register indices, reset values and field positions of the shared-pin GPIO block
`ifndef SHARED_PIN_GPIO_MAP_VH
`define SHARED_PIN_GPIO_MAP_VH

// Register indices; byte address is four times the index
`define IDX_EN_LOW      16'h4400
`define IDX_DIR_LOW     16'h4401
`define IDX_VAL_LOW     16'h4402
`define IDX_EN_MID      16'h4403
`define IDX_DIR_MID     16'h4404
`define IDX_VAL_MID     16'h4405
`define IDX_EN_HIGH     16'h4406
`define IDX_DIR_HIGH    16'h4407
`define IDX_VAL_HIGH    16'h4408
`define IDX_BUS_SEL     16'h4410

// Index field inside the byte address and the upper bits that must be zero
`define ADDR_IDX_LSB    2
`define ADDR_IDX_MSB    17
`define ADDR_TOP_LSB    18

// Bus selection field position and values
`define BUS_SEL_MUX_BIT 0
`define MUX_GPIO        1'b0
`define MUX_FULL        1'b1
`define BUS_SEL_RESET   1'b1

// Reset values of the per-pin registers
`define EN_RESET        16'h0000
`define DIR_RESET       16'h0000
`define VAL_RESET       16'h0000

// Valid GPIO indices 0..45 within the 48-bit register space
`define PIN_MASK        48'h3FFF_FFFF_FFFF

`endif

// *** rtl/sync_bank.v ***
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module sync_bank #(
   parameter W = 46
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b0}};
         q        <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // sync_bank

// *** rtl/shared_pin_gpio_top.v ***
// Shared-pin GPIO block with AHB-Lite register slave
//
// Summary of operation
// - 46 shared pins individually enableable, only mux zero
// - Address, data, control, host pins map indices 0..45
// - Mux one gives pins full interface functions
// - Enable bits never override the mux setting
// - Enable zero: GPIO off, pin high impedance
// - Enable one: pin follows direction and data bits
// - Direction zero input, one output
// - Enable, direction, data register groups
// - First enable/direction registers hold indices 0..15
// - Input reads pin level; output drives written bit
`timescale 1ns/1ps
`include "shared_pin_gpio_map.vh"
module shared_pin_gpio #(
   parameter PINS = 46
) (
   input  wire             CLK_SYS,
   input  wire             RESETN,
   input  wire             HSEL,
   input  wire [31:0]      HADDR,
   input  wire [1:0]       HTRANS,
   input  wire             HWRITE,
   input  wire [2:0]       HSIZE,
   input  wire [31:0]      HWDATA,
   input  wire             HREADY,
   output reg  [31:0]      HRDATA,
   output reg              HREADYOUT,
   output reg              HRESP,
   input  wire [PINS-1:0]  PIN_IN,
   output reg  [PINS-1:0]  PIN_OUT,
   output reg  [PINS-1:0]  PIN_OE,
   input  wire [PINS-1:0]  FUNC_OUT,
   input  wire [PINS-1:0]  FUNC_OE,
   output reg  [PINS-1:0]  FUNC_IN,
   output reg              MUX_FULL_MODE
);
   localparam SETS = 3;

   // Gathered from the per-set registers so each bit has one driver
   wire [47:0]     en_reg;
   wire [47:0]     dir_reg;
   wire [47:0]     val_reg;
   reg             mux_reg;
   reg             wr_pend_reg;
   reg             rd_pend_reg;
   reg  [15:0]     idx_reg;
   reg             top_ok_reg;
   wire [PINS-1:0] pin_sync;
   wire [47:0]     pin_level;
   wire [47:0]     en_m;
   wire [47:0]     dir_m;
   wire [47:0]     rd_val;
   wire            accept;
   wire [15:0]     idx_now;
   reg  [15:0]     rd_word;

   // Pin levels pass two flops before anything reads them
   sync_bank #(
      .W (PINS)
   ) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RESETN),
      .d     (PIN_IN),
      .q     (pin_sync)
   );

   assign pin_level = {{(48-PINS){1'b0}}, pin_sync};
   assign en_m      = en_reg & `PIN_MASK;
   assign dir_m     = dir_reg & `PIN_MASK;
   // Inputs return the pin level, outputs the value written
   assign rd_val    = ((dir_m & val_reg) | (~dir_m & pin_level)) & `PIN_MASK;

   assign accept  = HSEL & HTRANS[1] & HREADY;
   assign idx_now = HADDR[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

   // Bus address phase capture; reads take one wait state so a
   // preceding write is already visible
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg     <= 16'h0000;
         top_ok_reg  <= 1'b0;
         HREADYOUT   <= 1'b1;
         HRESP       <= 1'b0;
         HRDATA      <= 32'h0000_0000;
      end else begin
         HRESP <= 1'b0;
         if (rd_pend_reg) begin
            HRDATA      <= {16'h0000, rd_word};
            HREADYOUT   <= 1'b1;
            rd_pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
         end else if (accept) begin
            idx_reg     <= idx_now;
            top_ok_reg  <= (HADDR[31:`ADDR_TOP_LSB] == 14'h0000);
            wr_pend_reg <= HWRITE;
            rd_pend_reg <= ~HWRITE;
            HREADYOUT   <= HWRITE;
         end else begin
            wr_pend_reg <= 1'b0;
         end
      end
   end

   // Read mux; unmapped indices and absent pins read zero
   always @* begin
      rd_word = 16'h0000;
      if (top_ok_reg) begin
         case (idx_reg)
            `IDX_EN_LOW:   rd_word = en_m[15:0];
            `IDX_DIR_LOW:  rd_word = dir_m[15:0];
            `IDX_VAL_LOW:  rd_word = rd_val[15:0];
            `IDX_EN_MID:   rd_word = en_m[31:16];
            `IDX_DIR_MID:  rd_word = dir_m[31:16];
            `IDX_VAL_MID:  rd_word = rd_val[31:16];
            `IDX_EN_HIGH:  rd_word = en_m[47:32];
            `IDX_DIR_HIGH: rd_word = dir_m[47:32];
            `IDX_VAL_HIGH: rd_word = rd_val[47:32];
            `IDX_BUS_SEL:  rd_word = {15'h0000, mux_reg};
            default:       rd_word = 16'h0000;
         endcase
      end
   end

   // Per-set enable, direction and data registers
   genvar k;
   generate
      for (k = 0; k < SETS; k = k + 1) begin : g_set
         localparam [15:0] STEP = 3 * k;
         wire [15:0] en_idx;
         wire [15:0] dir_idx;
         wire [15:0] val_idx;
         reg  [15:0] en_set_reg;
         reg  [15:0] dir_set_reg;
         reg  [15:0] val_set_reg;
         assign en_idx  = `IDX_EN_LOW + STEP;
         assign dir_idx = `IDX_DIR_LOW + STEP;
         assign val_idx = `IDX_VAL_LOW + STEP;
         assign en_reg[16*k +: 16]  = en_set_reg;
         assign dir_reg[16*k +: 16] = dir_set_reg;
         assign val_reg[16*k +: 16] = val_set_reg;
         always @(posedge CLK_SYS or negedge RESETN) begin
            if (!RESETN) begin
               en_set_reg  <= `EN_RESET;
               dir_set_reg <= `DIR_RESET;
               val_set_reg <= `VAL_RESET;
            end else if (wr_pend_reg && top_ok_reg) begin
               if (idx_reg == en_idx)
                  en_set_reg <= HWDATA[15:0];
               if (idx_reg == dir_idx)
                  dir_set_reg <= HWDATA[15:0];
               if (idx_reg == val_idx)
                  val_set_reg <= HWDATA[15:0];
            end
         end
      end
   endgenerate

   // Bus selection register
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         mux_reg <= `BUS_SEL_RESET;
      end else if (wr_pend_reg && top_ok_reg && idx_reg == `IDX_BUS_SEL) begin
         mux_reg <= HWDATA[`BUS_SEL_MUX_BIT];
      end
   end

   // Pin drive: index order is A[21:18]=3..0, D[31:16]=19..4,
   // C[15:0]=35..20, host data=43..36, host control 0/1=44/45
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PIN_OUT       <= {PINS{1'b0}};
         PIN_OE        <= {PINS{1'b0}};
         FUNC_IN       <= {PINS{1'b0}};
         MUX_FULL_MODE <= 1'b0;
      end else begin
         FUNC_IN       <= pin_sync;
         MUX_FULL_MODE <= mux_reg;
         if (mux_reg == `MUX_FULL) begin
            PIN_OUT <= FUNC_OUT;
            PIN_OE  <= FUNC_OE;
         end else begin
            PIN_OUT <= val_reg[PINS-1:0];
            // Disabled pins float; enabled pins drive only as outputs
            PIN_OE  <= en_m[PINS-1:0] & dir_m[PINS-1:0];
         end
      end
   end
endmodule // shared_pin_gpio

// *** verif/shared_pin_gpio_assertions.sv ***
// Bus and pin-mux assertions for the shared-pin GPIO block
`timescale 1ns/1ps
module shared_pin_gpio_checks #(parameter PINS = 46) (
   input wire            CLK_SYS, RESETN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
   input wire            MUX_FULL_MODE,
   input wire [1:0]      HTRANS,
   input wire [31:0]     HRDATA,
   input wire [PINS-1:0] PIN_OUT, PIN_OE, FUNC_OUT, FUNC_OE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   wire take = HSEL && HTRANS[1] && HREADY;
   chk_resp_okay: assert property (!HRESP) else $error("bad response");
   chk_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait wrong");
   chk_write_nowait: assert property (take && HWRITE |=> HREADYOUT) else $error("write stall");
   chk_wait_single: assert property (!HREADYOUT |=> HREADYOUT) else $error("long wait");
   chk_rdata_upper: assert property (HRDATA[31:16] == 16'h0000)
      else $error("upper bits set");
   chk_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
      else $error("read data moved");
   chk_full_oe: assert property (MUX_FULL_MODE |-> PIN_OE == $past(FUNC_OE))
      else $error("enable not function");
   chk_full_out: assert property (MUX_FULL_MODE |-> PIN_OUT == $past(FUNC_OUT))
      else $error("level not function");
   cover property (take && !HWRITE);
   cover property (take && HWRITE);
   cover property (!MUX_FULL_MODE && |PIN_OE);
endmodule // shared_pin_gpio_checks
bind shared_pin_gpio shared_pin_gpio_checks #(.PINS(PINS)) chk_i (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
   .HSEL(HSEL), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .MUX_FULL_MODE(MUX_FULL_MODE), .HTRANS(HTRANS), .HRDATA(HRDATA), .PIN_OUT(PIN_OUT),
   .PIN_OE(PIN_OE), .FUNC_OUT(FUNC_OUT), .FUNC_OE(FUNC_OE));

// *** verif/board_pins.sv ***
// Board-side drivers on the shared pins
`timescale 1ns/1ps
module board_pins (
   input  wire [45:0] oe,
   input  wire [45:0] out,
   input  wire [45:0] ext,
   output wire [45:0] level
);
   // Where the block releases a pin the board's own driver sets the level
   assign level = (oe & out) | (~oe & ext);
endmodule // board_pins

// *** verif/tb.sv ***
// Self-checking bench for the shared-pin GPIO block
`timescale 1ns/1ps
`include "shared_pin_gpio_map.vh"
module tb;
   reg         clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   reg  [1:0]  htrans = 2'h0;
   reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   reg  [45:0] ext = 46'h2A5A_C3C3_0F96;
   reg  [47:0] x;
   wire [31:0] hrdata;
   wire        hready, hresp, mux;
   wire [45:0] pout, poe, pin, fin;
   localparam [45:0] FOE = 46'h1234_5678_9ABC, FOUT = 46'h0FED_CBA9_8765;
   localparam [47:0] E = 48'hFC3C_5A5A_FF0F, D = 48'h3FF0_33CC_F0FF, V = 48'h2DB6_A5A5_9669;
   integer     mismatches = 0, n_compared = 0, cycles = 0, i;
   always #4 clk = ~clk;
   shared_pin_gpio uut (.CLK_SYS(clk), .RESETN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe),
      .FUNC_OUT(FOUT), .FUNC_OE(FOE), .FUNC_IN(fin), .MUX_FULL_MODE(mux));
   board_pins brd (.oe(poe), .out(pout), .ext(ext), .level(pin));
   task chk(input [63:0] seen, input [63:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input [15:0] idx, input w, input [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {14'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk iff hready);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk iff hready);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         wrap_up;
      end
   end
   task t_reset;
      bus(`IDX_EN_LOW, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(`IDX_DIR_LOW, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(`IDX_BUS_SEL, 1'b0, 32'h0);
      chk(rd, 32'h1);
      bus(16'h4409, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(mux, 1'b1);
   endtask
   task t_full;
      for (i = 0; i < 3; i = i + 1) begin
         bus(16'h4400 + 16'(3 * i), 1'b1, {16'h0, E[16*i +: 16]});
         bus(16'h4401 + 16'(3 * i), 1'b1, {16'h0, D[16*i +: 16]});
         bus(16'h4402 + 16'(3 * i), 1'b1, {16'h0, V[16*i +: 16]});
      end
      repeat (4) @(posedge clk);
      chk(poe, FOE);
      chk(pout, FOUT);
      chk(fin, (FOE & FOUT) | (~FOE & ext));
   endtask
   task t_gpio;
      ext <= ~ext;
      bus(`IDX_BUS_SEL, 1'b1, 32'h0);
      repeat (4) @(posedge clk);
      chk(mux, 1'b0);
      chk(poe, E[45:0] & D[45:0]);
      chk(pout & poe, E[45:0] & D[45:0] & V[45:0]);
      x = (D & V) | (~D & {2'h0, ext});
      for (i = 0; i < 3; i = i + 1) begin
         bus(16'h4400 + 16'(3 * i), 1'b0, 32'h0);
         chk(rd, E[16*i +: 16] & ((i == 2) ? 16'h3FFF : 16'hFFFF));
         bus(16'h4401 + 16'(3 * i), 1'b0, 32'h0);
         chk(rd, D[16*i +: 16] & ((i == 2) ? 16'h3FFF : 16'hFFFF));
         bus(16'h4402 + 16'(3 * i), 1'b0, 32'h0);
         chk(rd, x[16*i +: 16] & ((i == 2) ? 16'h3FFF : 16'hFFFF));
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_full;
      t_gpio;
      wrap_up;
   end
endmodule // tb
